// *** rtl/cec_defines.svh ***
// constants for the command error checker: codes, offsets, fields
`ifndef CEC_DEFINES_SVH
`define CEC_DEFINES_SVH

`define CEC_ERR_NONE 8'h00
`define CEC_ERR_STATE 8'h64
`define CEC_ERR_OVER 8'h65
`define CEC_ERR_UNDER 8'h66
`define CEC_ERR_ADDR 8'h67
`define CEC_ERR_COUNT 8'h68
`define CEC_ERR_DATA 8'h69
`define CEC_ERR_CHOICE 8'h6A
`define CEC_ERR_UNSTABLE 8'h78
`define CEC_ERR_NEGATIVE 8'h79
`define CEC_ERR_RELATIVE 8'h7A
`define CEC_ERR_SETPOINT 8'h7C
`define CEC_ERR_TARE_ZERO 8'h7E
`define CEC_ERR_REMOTE 8'h7F
`define CEC_ERR_SETUP 8'h82
`define CEC_ERR_PORT 8'h84
`define CEC_ERR_LOCKED 8'h85
`define CEC_ERR_OPTION 8'h86
`define CEC_ERR_PRN_FULL 8'h8A
`define CEC_ERR_PRN_NONE 8'h8B
`define CEC_ERR_BUSY 8'h8C

// register offsets (word index on the plain port)
`define CEC_REG_CTRL 4'h0
`define CEC_REG_STATUS 4'h1
`define CEC_REG_LIMIT_HI 4'h2
`define CEC_REG_LIMIT_LO 4'h3
`define CEC_REG_REG_BASE 4'h4
`define CEC_REG_REG_TOP 4'h5
`define CEC_REG_OPTIONS 4'h6
`define CEC_REG_RESULT 4'h7
`define CEC_REG_COUNTS 4'h8

// control register fields
`define CEC_CTRL_MOTION 0
`define CEC_CTRL_UNIPOLAR 1
`define CEC_CTRL_LEGAL_LOCK 2
`define CEC_CTRL_PRN_CFG 3
`define CEC_CTRL_SETPT_OFF 4
`define CEC_CTRL_RESET 16'h0000

// reset values, register count limit and port numbers
`define CEC_LIMIT_HI_RESET 16'hFFFF
`define CEC_LIMIT_LO_RESET 16'h0000
`define CEC_REG_BASE_RESET 16'h0000
`define CEC_REG_TOP_RESET 16'h00FF
`define CEC_OPTIONS_RESET 16'h0000
`define CEC_MAX_REG_COUNT 8'h7B
`define CEC_UPGRADE_PORT 2'h1
`define CEC_PRINT_PORT_NONE 2'h0

`endif

// *** rtl/cec_pkg.sv ***
// types shared by the command error checker
package cec_pkg;

    typedef enum logic [3:0] {
        CEC_CMD_ZERO,
        CEC_CMD_REL_ZERO,
        CEC_CMD_PRINT,
        CEC_CMD_SHOW_REL,
        CEC_CMD_REMOTE,
        CEC_CMD_SETUP,
        CEC_CMD_RESTORE,
        CEC_CMD_DEFAULT,
        CEC_CMD_UPGRADE,
        CEC_CMD_SETPOINT,
        CEC_CMD_PARAM,
        CEC_CMD_REG_WRITE,
        CEC_CMD_OTHER
    } cec_cmd_e;

    typedef enum logic [1:0] {
        CEC_IDLE,
        CEC_CHECK,
        CEC_REPORT
    } cec_state_e;

endpackage : cec_pkg

// *** rtl/cec_range_check.sv ***
// range checks of a value and of a register write window
`timescale 1ns/1ps
`default_nettype none
module cec_range_check (
    input wire logic [15:0] value_i,
    input wire logic [15:0] limit_hi_i,
    input wire logic [15:0] limit_lo_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_count_i,
    input wire logic [15:0] reg_base_i,
    input wire logic [15:0] reg_top_i,
    output logic over_o,
    output logic under_o,
    output logic bad_addr_o,
    output logic bad_count_o
);
    `include "cec_defines.svh"

    logic [16:0] last_addr;

    // the count is checked against the window end, not only its maximum
    assign last_addr = {1'b0, reg_addr_i} + {9'h000, reg_count_i} - 17'h0_0001;
    assign over_o = value_i > limit_hi_i;
    assign under_o = value_i < limit_lo_i;
    assign bad_addr_o = (reg_addr_i < reg_base_i) || (reg_addr_i > reg_top_i);
    assign bad_count_o = (reg_count_i == 8'h00)
        || (reg_count_i > `CEC_MAX_REG_COUNT)
        || (last_addr > {1'b0, reg_top_i});
endmodule : cec_range_check
`default_nettype wire

// *** rtl/cec_checker.sv ***
// command error checker: validates commands and reports one general error
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cec_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // command from panel or serial link
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_i,
    input wire logic [15:0] cmd_value_i,
    input wire logic [15:0] cmd_addr_i,
    input wire logic [7:0] cmd_count_i,
    input wire logic cmd_data_bad_i,
    input wire logic cmd_choice_bad_i,
    input wire logic [3:0] cmd_option_i,
    input wire logic cmd_needs_option_i,
    input wire logic [1:0] cmd_port_i,
    // instrument state from the same clock domain
    input wire logic mode_ok_i,
    input wire logic setup_ok_i,
    input wire logic force_stable_i,
    input wire logic force_negative_i,
    input wire logic relative_mode_i,
    input wire logic tare_zero_i,
    input wire logic showing_force_i,
    input wire logic busy_i,
    input wire logic prn_full_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // answer
    output logic done_o,
    output logic accept_o,
    output logic [7:0] err_code_o
);
    `include "cec_defines.svh"

    cec_pkg::cec_state_e state_reg, state_next;
    logic [15:0] ctrl_reg, limit_hi_reg, limit_lo_reg;
    logic [15:0] reg_base_reg, reg_top_reg, options_reg;
    logic [7:0] last_err_reg, err_next;
    logic [7:0] acc_cnt_reg, rej_cnt_reg;
    logic [15:0] rdata_reg;
    logic done_reg, accept_reg;
    logic [7:0] code_reg;
    cec_pkg::cec_cmd_e cmd_reg;
    logic [15:0] value_reg, addr_reg;
    logic [7:0] count_reg;
    logic data_bad_reg, choice_bad_reg, needs_opt_reg;
    logic [3:0] opt_reg;
    logic [1:0] port_reg;

    logic over, under, bad_addr, bad_count;
    logic is_zero, is_rel, is_print, is_wr, is_param;
    logic motion_on, unipolar, locked, prn_cfg, setpt_off;
    logic opt_missing, unstable_err;
    logic [7:0] code_sel;

    cec_range_check u_range (
        .value_i(value_reg),
        .limit_hi_i(limit_hi_reg),
        .limit_lo_i(limit_lo_reg),
        .reg_addr_i(addr_reg),
        .reg_count_i(count_reg),
        .reg_base_i(reg_base_reg),
        .reg_top_i(reg_top_reg),
        .over_o(over),
        .under_o(under),
        .bad_addr_o(bad_addr),
        .bad_count_o(bad_count)
    );

    assign motion_on = ctrl_reg[`CEC_CTRL_MOTION];
    assign unipolar = ctrl_reg[`CEC_CTRL_UNIPOLAR];
    assign locked = ctrl_reg[`CEC_CTRL_LEGAL_LOCK];
    assign prn_cfg = ctrl_reg[`CEC_CTRL_PRN_CFG];
    assign setpt_off = ctrl_reg[`CEC_CTRL_SETPT_OFF];
    assign is_zero = cmd_reg == cec_pkg::CEC_CMD_ZERO;
    assign is_rel = cmd_reg == cec_pkg::CEC_CMD_REL_ZERO;
    assign is_print = cmd_reg == cec_pkg::CEC_CMD_PRINT;
    assign is_wr = cmd_reg == cec_pkg::CEC_CMD_REG_WRITE;
    assign is_param = cmd_reg == cec_pkg::CEC_CMD_PARAM;
    assign opt_missing = needs_opt_reg && !options_reg[opt_reg];
    // zero setting always needs stability; relative zero and print only with motion check
    assign unstable_err = !force_stable_i
        && (is_zero || (motion_on && (is_rel || is_print)));

    // fixed priority: earlier lines win when several checks fail
    always_comb begin
        code_sel = `CEC_ERR_NONE;
        if (busy_i) begin
            code_sel = `CEC_ERR_BUSY;
        end else if (opt_missing) begin
            code_sel = `CEC_ERR_OPTION;
        end else if (choice_bad_reg) begin
            code_sel = `CEC_ERR_CHOICE;
        end else if (is_wr && bad_addr) begin
            code_sel = `CEC_ERR_ADDR;
        end else if (is_wr && bad_count) begin
            code_sel = `CEC_ERR_COUNT;
        end else if (is_wr && data_bad_reg) begin
            code_sel = `CEC_ERR_DATA;
        end else if (is_param && over) begin
            code_sel = `CEC_ERR_OVER;
        end else if (is_param && under) begin
            code_sel = `CEC_ERR_UNDER;
        end else if (locked && (cmd_reg == cec_pkg::CEC_CMD_UPGRADE
                || cmd_reg == cec_pkg::CEC_CMD_DEFAULT
                || cmd_reg == cec_pkg::CEC_CMD_RESTORE)) begin
            code_sel = `CEC_ERR_LOCKED;
        end else if (cmd_reg == cec_pkg::CEC_CMD_UPGRADE
                && port_reg != `CEC_UPGRADE_PORT) begin
            code_sel = `CEC_ERR_PORT;
        end else if ((cmd_reg == cec_pkg::CEC_CMD_SETUP
                || cmd_reg == cec_pkg::CEC_CMD_RESTORE) && !setup_ok_i) begin
            code_sel = `CEC_ERR_SETUP;
        end else if (cmd_reg == cec_pkg::CEC_CMD_REMOTE
                && !showing_force_i) begin
            code_sel = `CEC_ERR_REMOTE;
        end else if (!mode_ok_i) begin
            code_sel = `CEC_ERR_STATE;
        end else if (is_zero && relative_mode_i) begin
            code_sel = `CEC_ERR_RELATIVE;
        end else if (unstable_err) begin
            code_sel = `CEC_ERR_UNSTABLE;
        end else if (is_rel && unipolar && force_negative_i) begin
            code_sel = `CEC_ERR_NEGATIVE;
        end else if (cmd_reg == cec_pkg::CEC_CMD_SETPOINT && setpt_off) begin
            code_sel = `CEC_ERR_SETPOINT;
        end else if (cmd_reg == cec_pkg::CEC_CMD_SHOW_REL && tare_zero_i) begin
            code_sel = `CEC_ERR_TARE_ZERO;
        end else if (is_print && !prn_cfg) begin
            code_sel = `CEC_ERR_PRN_NONE;
        end else if (is_print && prn_full_i) begin
            code_sel = `CEC_ERR_PRN_FULL;
        end
    end

    // one command at a time; new commands while checking are ignored
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cec_pkg::CEC_IDLE: begin
                if (cmd_valid_i) begin
                    state_next = cec_pkg::CEC_CHECK;
                end
            end
            cec_pkg::CEC_CHECK: begin
                state_next = cec_pkg::CEC_REPORT;
            end
            default: begin
                state_next = cec_pkg::CEC_IDLE;
            end
        endcase
    end

    wire take_cmd = (state_reg == cec_pkg::CEC_IDLE) && cmd_valid_i;
    wire check = state_reg == cec_pkg::CEC_CHECK;
    wire wr_ctrl = wr_i && (addr_i == `CEC_REG_CTRL);
    wire wr_hi = wr_i && (addr_i == `CEC_REG_LIMIT_HI);
    wire wr_lo = wr_i && (addr_i == `CEC_REG_LIMIT_LO);
    wire wr_base = wr_i && (addr_i == `CEC_REG_REG_BASE);
    wire wr_top = wr_i && (addr_i == `CEC_REG_REG_TOP);
    wire wr_opt = wr_i && (addr_i == `CEC_REG_OPTIONS);
    assign err_next = check ? code_sel : last_err_reg;

    logic [15:0] rd_sel;
    always_comb begin
        if (addr_i == `CEC_REG_CTRL) begin
            rd_sel = ctrl_reg;
        end else if (addr_i == `CEC_REG_STATUS) begin
            rd_sel = {14'h0000, accept_reg, state_reg != cec_pkg::CEC_IDLE};
        end else if (addr_i == `CEC_REG_LIMIT_HI) begin
            rd_sel = limit_hi_reg;
        end else if (addr_i == `CEC_REG_LIMIT_LO) begin
            rd_sel = limit_lo_reg;
        end else if (addr_i == `CEC_REG_REG_BASE) begin
            rd_sel = reg_base_reg;
        end else if (addr_i == `CEC_REG_REG_TOP) begin
            rd_sel = reg_top_reg;
        end else if (addr_i == `CEC_REG_OPTIONS) begin
            rd_sel = options_reg;
        end else if (addr_i == `CEC_REG_RESULT) begin
            rd_sel = {8'h00, last_err_reg};
        end else if (addr_i == `CEC_REG_COUNTS) begin
            rd_sel = {rej_cnt_reg, acc_cnt_reg};
        end else begin
            rd_sel = 16'h0000;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= `CEC_CTRL_RESET;
            limit_hi_reg <= `CEC_LIMIT_HI_RESET;
            limit_lo_reg <= `CEC_LIMIT_LO_RESET;
            reg_base_reg <= `CEC_REG_BASE_RESET;
            reg_top_reg <= `CEC_REG_TOP_RESET;
            options_reg <= `CEC_OPTIONS_RESET;
            rdata_reg <= 16'h0000;
        end else if (clk_en_i) begin
            if (wr_ctrl) ctrl_reg <= wdata_i;
            if (wr_hi) limit_hi_reg <= wdata_i;
            if (wr_lo) limit_lo_reg <= wdata_i;
            if (wr_base) reg_base_reg <= wdata_i;
            if (wr_top) reg_top_reg <= wdata_i;
            if (wr_opt) options_reg <= wdata_i;
            rdata_reg <= rd_i ? rd_sel : 16'h0000;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_reg <= cec_pkg::CEC_CMD_OTHER;
            value_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            count_reg <= 8'h00;
            data_bad_reg <= 1'b0;
            choice_bad_reg <= 1'b0;
            needs_opt_reg <= 1'b0;
            opt_reg <= 4'h0;
            port_reg <= 2'h0;
        end else if (clk_en_i && take_cmd) begin
            cmd_reg <= cec_pkg::cec_cmd_e'(cmd_i);
            value_reg <= cmd_value_i;
            addr_reg <= cmd_addr_i;
            count_reg <= cmd_count_i;
            data_bad_reg <= cmd_data_bad_i;
            choice_bad_reg <= cmd_choice_bad_i;
            needs_opt_reg <= cmd_needs_option_i;
            opt_reg <= cmd_option_i;
            port_reg <= cmd_port_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= cec_pkg::CEC_IDLE;
            last_err_reg <= `CEC_ERR_NONE;
            done_reg <= 1'b0;
            accept_reg <= 1'b0;
            code_reg <= `CEC_ERR_NONE;
            acc_cnt_reg <= 8'h00;
            rej_cnt_reg <= 8'h00;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            last_err_reg <= err_next;
            done_reg <= check;
            if (check) begin
                accept_reg <= code_sel == `CEC_ERR_NONE;
                code_reg <= code_sel;
                if (code_sel == `CEC_ERR_NONE) begin
                    acc_cnt_reg <= acc_cnt_reg + 8'h01;
                end else begin
                    rej_cnt_reg <= rej_cnt_reg + 8'h01;
                end
            end
        end
    end

    assign rdata_o = rdata_reg;
    assign done_o = done_reg;
    assign accept_o = accept_reg;
    assign err_code_o = code_reg;

    a_zero_relative: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        check && clk_en_i && !busy_i && !opt_missing && !choice_bad_reg
            && mode_ok_i && is_zero && relative_mode_i
        |=> err_code_o == `CEC_ERR_RELATIVE && done_o)
        else $error("relative mode zero not rejected");
    a_zero_unstable: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        check && clk_en_i && code_sel == `CEC_ERR_NONE && is_zero
        |-> force_stable_i)
        else $error("zero accepted with unstable force");
    a_lock_upgrade: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        check && clk_en_i && locked && !busy_i && !opt_missing
            && !choice_bad_reg && cmd_reg == cec_pkg::CEC_CMD_UPGRADE
        |=> !accept_o && err_code_o == `CEC_ERR_LOCKED)
        else $error("locked upgrade not rejected");
    a_upgrade_port: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o && accept_o && $past(cmd_reg) == cec_pkg::CEC_CMD_UPGRADE
        |-> $past(port_reg) == `CEC_UPGRADE_PORT)
        else $error("upgrade accepted on wrong port");
    a_param_over: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        check && clk_en_i && is_param && over && !busy_i && !opt_missing
            && !choice_bad_reg
        |=> err_code_o == `CEC_ERR_OVER)
        else $error("over range not reported");
    a_param_under: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o && accept_o && $past(is_param) |-> !$past(under))
        else $error("under range accepted");
    a_write_addr: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o && accept_o && $past(is_wr)
        |-> !$past(bad_addr) && !$past(bad_count) && !$past(data_bad_reg))
        else $error("bad register write accepted");
    a_print_full: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        done_o && accept_o && $past(is_print) |-> !$past(prn_full_i))
        else $error("print accepted with full buffer");
    a_one_answer: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        take_cmd && clk_en_i ##1 clk_en_i ##1 clk_en_i |-> done_o
            && (accept_o == (err_code_o == `CEC_ERR_NONE)))
        else $error("answer missing or inconsistent");

    c_accept: cover property (@(posedge clk_i) done_o && accept_o);
    c_unstable: cover property (@(posedge clk_i)
        done_o && err_code_o == `CEC_ERR_UNSTABLE);
    c_locked: cover property (@(posedge clk_i)
        done_o && err_code_o == `CEC_ERR_LOCKED);
    c_write_bad: cover property (@(posedge clk_i)
        done_o && err_code_o == `CEC_ERR_COUNT);
endmodule : cec_checker
`default_nettype wire

// *** dv/cec_host_model.sv ***
// control computer model: drives one command and collects the answer
`timescale 1ns/1ps
`default_nettype none
module cec_host_model (
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic accept_i,
    input wire logic [7:0] err_code_i,
    output logic cmd_valid_o,
    output logic [3:0] cmd_o,
    output logic [15:0] value_o,
    output logic [15:0] addr_o,
    output logic [7:0] count_o,
    output logic [2:0] flags_o,
    output logic [3:0] option_o,
    output logic [1:0] port_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 4'hF;
        value_o = 16'h0000;
        addr_o = 16'h0000;
        count_o = 8'h00;
        flags_o = 3'h0;
        option_o = 4'h0;
        port_o = 2'h0;
    end

    // released fields are scrambled so nothing leans on stale values
    task automatic release_bus();
        cmd_valid_o <= 1'b0;
        cmd_o <= ~cmd_o;
        value_o <= ~value_o;
        addr_o <= ~addr_o;
        count_o <= ~count_o;
        flags_o <= ~flags_o;
        option_o <= ~option_o;
        port_o <= ~port_o;
    endtask : release_bus

    // extra keeps valid up one more cycle with another command in it
    task automatic send(input logic [3:0] c, input logic [15:0] v,
        input logic [15:0] a, input logic [7:0] n, input logic [2:0] f,
        input logic [3:0] o, input logic [1:0] p, input bit extra,
        output int lat, output logic acc, output logic [7:0] code,
        output int nd);
        lat = 0;
        nd = 0;
        acc = 1'bx;
        code = 8'hxx;
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        value_o <= v;
        addr_o <= a;
        count_o <= n;
        flags_o <= f;
        option_o <= o;
        port_o <= p;
        for (int k = 1; k <= 8; k++) begin
            @(negedge clk_i);
            if (done_i === 1'b1) begin
                nd++;
                if (lat == 0) begin
                    lat = k;
                    acc = accept_i;
                    code = err_code_i;
                end
            end
            @(posedge clk_i);
            if (k == 1 && extra) cmd_o <= cec_pkg::CEC_CMD_OTHER;
            else if (k == (extra ? 2 : 1)) release_bus();
        end
    endtask : send
endmodule : cec_host_model
`default_nettype wire

// *** dv/tb.sv ***
// self-checking testbench of the command error checker
`timescale 1ns/1ps
`default_nettype none
`include "cec_defines.svh"
module tb;
    localparam logic [8:0] BASE_ST = 9'h047;
    localparam logic [15:0] CV = 16'h0009;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    // 0 mode ok,1 setup ok,2 stable,3 negative,4 relative,5 tare zero,
    // 6 showing force,7 busy,8 printer full
    logic [8:0] st = BASE_ST;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    wire logic [15:0] rdata_o;
    wire logic done_o;
    wire logic accept_o;
    wire logic [7:0] err_code_o;
    wire logic cmd_valid_i;
    wire logic [3:0] cmd_i;
    wire logic [15:0] cmd_value_i;
    wire logic [15:0] cmd_addr_i;
    wire logic [7:0] cmd_count_i;
    wire logic [2:0] cmd_flags;
    wire logic [3:0] cmd_option_i;
    wire logic [1:0] cmd_port_i;
    logic [15:0] sh [16];
    logic [3:0] c_cmd;
    logic [15:0] c_val;
    logic [15:0] c_addr;
    logic [7:0] c_cnt;
    logic c_db, c_cb, c_no;
    logic [3:0] c_opt;
    logic [1:0] c_port;
    int error_cnt = 0;
    int checks = 0;
    int nacc = 0, nrej = 0;

    always #5 clk_i = ~clk_i;

    cec_host_model i_cec_host_model (.clk_i(clk_i), .done_i(done_o),
        .accept_i(accept_o), .err_code_i(err_code_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .value_o(cmd_value_i),
        .addr_o(cmd_addr_i), .count_o(cmd_count_i), .flags_o(cmd_flags),
        .option_o(cmd_option_i), .port_o(cmd_port_i));

    cec_checker i_cec_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(1'b1), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_value_i(cmd_value_i), .cmd_addr_i(cmd_addr_i),
        .cmd_count_i(cmd_count_i), .cmd_data_bad_i(cmd_flags[2]),
        .cmd_choice_bad_i(cmd_flags[1]), .cmd_option_i(cmd_option_i),
        .cmd_needs_option_i(cmd_flags[0]), .cmd_port_i(cmd_port_i),
        .mode_ok_i(st[0]), .setup_ok_i(st[1]), .force_stable_i(st[2]),
        .force_negative_i(st[3]), .relative_mode_i(st[4]),
        .tare_zero_i(st[5]), .showing_force_i(st[6]), .busy_i(st[7]),
        .prn_full_i(st[8]), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .done_o(done_o),
        .accept_o(accept_o), .err_code_o(err_code_o));

    // one code per command, highest priority first
    function automatic logic [7:0] exp_code();
        logic [16:0] last;
        logic [12:0] k;
        last = {1'b0, c_addr} + 17'(c_cnt) - 17'h0_0001;
        // k is one-hot by command enum index
        k = 13'h0001 << c_cmd;
        if (st[7]) return `CEC_ERR_BUSY;
        if (c_no && !sh[6][c_opt]) return `CEC_ERR_OPTION;
        if (c_cb) return `CEC_ERR_CHOICE;
        if (k[11] && (c_addr < sh[4] || c_addr > sh[5]))
            return `CEC_ERR_ADDR;
        if (k[11] && (c_cnt == 8'h00 || c_cnt > `CEC_MAX_REG_COUNT
            || last > {1'b0, sh[5]})) return `CEC_ERR_COUNT;
        if (k[11] && c_db) return `CEC_ERR_DATA;
        if (k[10] && c_val > sh[2]) return `CEC_ERR_OVER;
        if (k[10] && c_val < sh[3]) return `CEC_ERR_UNDER;
        if (sh[0][2] && |k[8:6]) return `CEC_ERR_LOCKED;
        if (k[8] && c_port != `CEC_UPGRADE_PORT) return `CEC_ERR_PORT;
        if (|k[6:5] && !st[1]) return `CEC_ERR_SETUP;
        if (k[4] && !st[6]) return `CEC_ERR_REMOTE;
        if (!st[0]) return `CEC_ERR_STATE;
        if (k[0] && st[4]) return `CEC_ERR_RELATIVE;
        if (!st[2] && (k[0] || sh[0][0] && |k[2:1]))
            return `CEC_ERR_UNSTABLE;
        if (k[1] && sh[0][1] && st[3]) return `CEC_ERR_NEGATIVE;
        if (k[9] && sh[0][4]) return `CEC_ERR_SETPOINT;
        if (k[3] && st[5]) return `CEC_ERR_TARE_ZERO;
        if (k[2] && !sh[0][3]) return `CEC_ERR_PRN_NONE;
        if (k[2] && st[8]) return `CEC_ERR_PRN_FULL;
        return `CEC_ERR_NONE;
    endfunction : exp_code

    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a == 4'h0 || (a >= 4'h2 && a <= 4'h6)) sh[a] = d;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : reg_rd

    task automatic go(input logic [7:0] code, input bit extra);
        int lat;
        int nd;
        logic acc;
        logic [7:0] got;
        logic [15:0] r;
        i_cec_host_model.send(c_cmd, c_val, c_addr, c_cnt,
            {c_db, c_cb, c_no}, c_opt, c_port, extra, lat, acc, got, nd);
        if (nd == 0) begin
            chk("done", 16'h0000, 16'h0001);
            finish_test();
        end
        chk("err_code", {8'h00, got}, {8'h00, code});
        chk("accept", {15'h0000, acc}, {15'h0000, code == 8'h00});
        chk("latency", 16'(lat), 16'h0003);
        chk("answers", 16'(nd), 16'h0001);
        if (code == 8'h00) nacc++;
        else nrej++;
        reg_rd(`CEC_REG_RESULT, r);
        chk("result", r, {8'h00, code});
    endtask : go

    // one condition flipped away from a state in which all is accepted
    task automatic dir(input logic [3:0] c, input int idx,
        input logic [15:0] cv, input logic [7:0] code);
        reg_wr(`CEC_REG_CTRL, cv);
        st <= (idx < 9) ? BASE_ST ^ (9'h001 << idx) : BASE_ST;
        c_cmd = c;
        c_val = 16'h0100;
        c_addr = 16'h0010;
        c_cnt = 8'h04;
        c_db = idx == 10;
        c_cb = idx == 9;
        c_no = idx == 11;
        c_opt = 4'h0;
        c_port = (idx == 12) ? 2'h2 : `CEC_UPGRADE_PORT;
        case (idx)
            13: c_val = 16'h1001;
            14: c_val = 16'h000F;
            15: c_addr = 16'h0100;
            16: c_cnt = 8'h00;
            17: c_cnt = 8'h7C;
            18: begin
                c_addr = 16'h0008;
                c_cnt = 8'h7B;
            end
            19: c_addr = 16'h0004;
            default: ;
        endcase
        go(code, 1'b0);
    endtask : dir

    initial begin
        logic [15:0] r;
        foreach (sh[i]) sh[i] = 16'h0000;
        sh[2] = `CEC_LIMIT_HI_RESET;
        sh[5] = `CEC_REG_TOP_RESET;
        void'($urandom(40816));
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        chk("reset outputs", {done_o, accept_o, err_code_o}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            reg_rd(4'(i), r);
            chk("reset value", r, sh[i]);
        end
        reg_wr(4'h9, 16'hA5A5);
        reg_wr(`CEC_REG_RESULT, 16'h1234);
        reg_rd(4'h9, r);
        chk("unmapped", r, 16'h0000);
        reg_rd(`CEC_REG_RESULT, r);
        chk("read only", r, 16'h0000);
        reg_wr(`CEC_REG_LIMIT_HI, 16'h1000);
        reg_wr(`CEC_REG_LIMIT_LO, 16'h0010);
        reg_wr(`CEC_REG_REG_BASE, 16'h0008);
        for (int i = 0; i < 13; i++) dir(4'(i), 31, CV, `CEC_ERR_NONE);
        dir(4'hC, 0, CV, `CEC_ERR_STATE);
        dir(4'hA, 13, CV, `CEC_ERR_OVER);
        dir(4'hA, 14, CV, `CEC_ERR_UNDER);
        dir(4'hB, 15, CV, `CEC_ERR_ADDR);
        dir(4'hB, 19, CV, `CEC_ERR_ADDR);
        dir(4'hB, 16, CV, `CEC_ERR_COUNT);
        dir(4'hB, 17, CV, `CEC_ERR_COUNT);
        dir(4'hB, 18, CV, `CEC_ERR_NONE);
        dir(4'hB, 10, CV, `CEC_ERR_DATA);
        dir(4'h9, 9, CV, `CEC_ERR_CHOICE);
        dir(4'h0, 2, 16'h0008, `CEC_ERR_UNSTABLE);
        dir(4'h1, 2, CV, `CEC_ERR_UNSTABLE);
        dir(4'h2, 2, CV, `CEC_ERR_UNSTABLE);
        dir(4'h1, 2, 16'h0008, `CEC_ERR_NONE);
        dir(4'h1, 3, 16'h000B, `CEC_ERR_NEGATIVE);
        dir(4'h1, 3, CV, `CEC_ERR_NONE);
        dir(4'h0, 4, CV, `CEC_ERR_RELATIVE);
        dir(4'h9, 31, 16'h0019, `CEC_ERR_SETPOINT);
        dir(4'h3, 5, CV, `CEC_ERR_TARE_ZERO);
        dir(4'h4, 6, CV, `CEC_ERR_REMOTE);
        dir(4'h5, 1, CV, `CEC_ERR_SETUP);
        dir(4'h6, 1, CV, `CEC_ERR_SETUP);
        dir(4'h8, 12, CV, `CEC_ERR_PORT);
        for (int i = 6; i < 9; i++)
            dir(4'(i), 31, 16'h000D, `CEC_ERR_LOCKED);
        dir(4'hA, 11, CV, `CEC_ERR_OPTION);
        reg_wr(`CEC_REG_OPTIONS, 16'h0001);
        dir(4'hA, 11, CV, `CEC_ERR_NONE);
        dir(4'h2, 8, CV, `CEC_ERR_PRN_FULL);
        dir(4'h2, 31, 16'h0001, `CEC_ERR_PRN_NONE);
        dir(4'h0, 7, CV, `CEC_ERR_BUSY);
        dir(4'h0, 31, CV, `CEC_ERR_NONE);
        go(`CEC_ERR_NONE, 1'b1);
        for (int n = 0; n < 150; n++) begin
            reg_wr(`CEC_REG_CTRL, 16'($urandom % 32));
            if (n % 16 == 0) reg_wr(`CEC_REG_OPTIONS, 16'($urandom));
            st <= BASE_ST ^ 9'($urandom & $urandom & $urandom);
            c_cmd = 4'($urandom % 13);
            c_val = 16'($urandom);
            c_addr = 16'($urandom % 512);
            c_cnt = 8'($urandom % 144);
            c_db = $urandom % 8 == 0;
            c_cb = $urandom % 8 == 0;
            c_no = $urandom % 8 == 0;
            c_opt = 4'($urandom);
            c_port = 2'($urandom);
            @(negedge clk_i);
            go(exp_code(), 1'b0);
        end
        reg_rd(`CEC_REG_COUNTS, r);
        chk("counts", r, {8'(nrej), 8'(nacc)});
        finish_test();
    end
endmodule : tb
`default_nettype wire
